//--- hdl/fdcrs_pkg.sv
// Shared constants and types of the rate control and result status block
package fdcrs_pkg;

  // ****************************************
  // Register word indices on the bus
  // ****************************************
  localparam logic [9:0] IDX_MODE_CFG = 10'h3F0;
  localparam logic [9:0] IDX_STATUS = 10'h3F1;
  localparam logic [9:0] IDX_DRIVE_OUT = 10'h3F2;
  localparam logic [9:0] IDX_DATA = 10'h3F5;
  localparam logic [9:0] IDX_RATE = 10'h3F7;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CFG_IDENT_BIT = 6;
  localparam int CFG_MFM_BIT = 5;
  localparam int DOR_DMA_GATE_BIT = 3;
  localparam int RATE_PRECOMP_BIT = 2;
  localparam int DIR_MEDIA_BIT = 7;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] CFG_RESET = 8'h40;
  localparam logic [1:0] RATE_RESET = 2'h2;
  localparam logic PRECOMP_RESET = 1'b0;
  localparam logic DMA_GATE_RESET = 1'b0;
  localparam logic DENSITY_RESET = 1'b1;
  localparam logic [3:0] DIR_P_ONES = 4'hF;

  // ****************************************
  // Status byte figures
  // ****************************************
  localparam int RECAL_STEP_LIMIT = 80;
  localparam int INDEX_LIMIT = 2;
  localparam logic [1:0] TERM_NORMAL = 2'h0;
  localparam logic [1:0] TERM_ABNORMAL = 2'h1;
  localparam logic [1:0] TERM_INVALID = 2'h2;
  localparam logic [1:0] TERM_POLLING = 2'h3;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    FDCRS_MODE_A = 3'b001,
    FDCRS_MODE_P = 3'b010,
    FDCRS_MODE_M = 3'b100
  } fdcrs_mode_type;

  typedef enum logic [2:0] {
    FDCRS_RES_IDLE = 3'b001,
    FDCRS_RES_ST0 = 3'b010,
    FDCRS_RES_ST1 = 3'b100
  } fdcrs_res_type;

endpackage : fdcrs_pkg

//--- hdl/fdcrs_status_enc.sv
// Builds the two result status bytes from the command engine's events
`timescale 1ns/1ps
`default_nettype none
module fdcrs_status_enc
  import fdcrs_pkg::*;
#(
  parameter int STEP_LIMIT = RECAL_STEP_LIMIT
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_cmd_start,
  input wire logic i_cmd_end,
  input wire logic [1:0] i_term_code,
  input wire logic i_head,
  input wire logic [1:0] i_drive,
  input wire logic i_seek_done,
  input wire logic i_recal_active,
  input wire logic i_step_pulse,
  input wire logic i_track_zero,
  input wire logic i_relseek_underflow,
  input wire logic i_end_of_track,
  input wire logic i_crc_err,
  input wire logic i_overrun,
  input wire logic i_sector_missing,
  input wire logic i_write_cmd_active,
  input wire logic i_write_prot,
  input wire logic i_id_search,
  input wire logic i_id_found,
  input wire logic i_index_pulse,
  input wire logic i_no_data_mark,
  output logic [7:0] o_st0_q,
  output logic [7:0] o_st1_q
);

  // The step counter is seven bits wide
  if (STEP_LIMIT < 1 || STEP_LIMIT > 127) begin : g_bad_step_limit
    $error("STEP_LIMIT out of range");
  end

  localparam logic [6:0] STEP_MAX = 7'(STEP_LIMIT);
  localparam logic [1:0] IDX_MAX = 2'(INDEX_LIMIT);

  // Sticky flags: se, ec, en, de, ov, nd, nw, ma
  logic [7:0] flags_q, flags_d, set_v;
  logic [6:0] step_q, step_d;
  logic [1:0] idx_q, idx_d;
  logic [7:0] st0_d, st1_d;

  always_comb begin
    step_d = step_q;
    if (i_cmd_start) begin
      step_d = 7'h00;
    end else if (i_recal_active && i_step_pulse && step_q != STEP_MAX) begin
      step_d = step_q + 7'h01;
    end
    idx_d = idx_q;
    if (i_cmd_start || i_id_found || !i_id_search) begin
      idx_d = 2'h0;
    end else if (i_index_pulse && idx_q != IDX_MAX) begin
      idx_d = idx_q + 2'h1;
    end
    set_v[7] = i_seek_done;
    set_v[6] = (i_recal_active && step_q == STEP_MAX && !i_track_zero)
               || i_relseek_underflow;
    set_v[5] = i_end_of_track;
    set_v[4] = i_crc_err;
    set_v[3] = i_overrun;
    set_v[2] = i_sector_missing;
    set_v[1] = i_write_cmd_active && i_write_prot;
    set_v[0] = (i_id_search && idx_q == IDX_MAX && !i_id_found)
               || i_no_data_mark;
    // A new event wins over the clear at command start
    flags_d = (flags_q & ~{8{i_cmd_start}}) | set_v;
    st0_d = o_st0_q;
    st1_d = o_st1_q;
    if (i_cmd_end) begin
      st0_d = {i_term_code, flags_d[7], flags_d[6], 1'b0, i_head, i_drive};
      st1_d = {flags_d[5], 1'b0, flags_d[4], flags_d[3], 1'b0,
               flags_d[2], flags_d[1], flags_d[0]};
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      flags_q <= 8'h00;
      step_q <= 7'h00;
      idx_q <= 2'h0;
      o_st0_q <= 8'h00;
      o_st1_q <= 8'h00;
    end else begin
      flags_q <= flags_d;
      step_q <= step_d;
      idx_q <= idx_d;
      o_st0_q <= st0_d;
      o_st1_q <= st1_d;
    end
  end

endmodule : fdcrs_status_enc
`default_nettype wire

//--- hdl/fdcrs_top.sv
// Rate control, input status and result status register bank
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps
`default_nettype none

module fdcrs_top
  import fdcrs_pkg::*;
#(
  parameter int STEP_LIMIT = RECAL_STEP_LIMIT
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  // Avalon-MM slave, word addressed
  input wire logic [9:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [3:0] i_byteenable,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // Drive cable pins
  input wire logic i_media_changed_flag_n,
  input wire logic i_track_zero_input,
  input wire logic i_write_prot,
  input wire logic i_index_input,
  output logic o_density_pin,
  // Command engine
  input wire logic i_soft_rst,
  input wire logic i_cmd_start,
  input wire logic i_cmd_end,
  input wire logic [1:0] i_term_code,
  input wire logic i_head,
  input wire logic [1:0] i_drive,
  input wire logic i_seek_done,
  input wire logic i_recal_active,
  input wire logic i_step_pulse,
  input wire logic i_relseek_underflow,
  input wire logic i_end_of_track,
  input wire logic i_crc_err,
  input wire logic i_overrun,
  input wire logic i_sector_missing,
  input wire logic i_write_cmd_active,
  input wire logic i_id_search,
  input wire logic i_id_found,
  input wire logic i_no_data_mark,
  output logic [1:0] o_rate_select,
  output logic o_result_phase
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Cable pins are asynchronous to i_clk; only stage two is ever read
  logic [3:0] pin_s1_q, pin_s2_q;
  logic idx_prev_q;
  logic media_sync, track_zero_input_sync, wp_sync, idx_sync, idx_pulse;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pin_s1_q <= 4'h0;
      pin_s2_q <= 4'h0;
      idx_prev_q <= 1'b0;
    end else begin
      pin_s1_q <= {i_index_input, i_write_prot, i_track_zero_input,
                   i_media_changed_flag_n};
      pin_s2_q <= pin_s1_q;
      idx_prev_q <= pin_s2_q[3];
    end
  end

  assign media_sync = pin_s2_q[0];
  assign track_zero_input_sync = pin_s2_q[1];
  assign wp_sync = pin_s2_q[2];
  assign idx_sync = pin_s2_q[3];
  assign idx_pulse = idx_sync && !idx_prev_q;

  // ****************************************
  // Bus handshake
  // ****************************************
  // Every access waits exactly one cycle so read data can be registered
  logic ack_q, ack_d;
  logic access, rd_take, wr_take;

  assign access = i_read || i_write;
  assign o_waitrequest = access && !ack_q;
  assign rd_take = i_read && ack_q;
  assign wr_take = i_write && ack_q && i_byteenable[0];

  always_comb begin
    ack_d = access && !ack_q;
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
    end
  end

  // ****************************************
  // Software registers
  // ****************************************
  logic [7:0] cfg_q, cfg_d;
  logic [1:0] rate_q, rate_d;
  logic precomp_off_q, precomp_off_d;
  logic dma_gate_q, dma_gate_d;
  logic density_q, density_d;
  fdcrs_mode_type mode;
  logic high_rate;

  always_comb begin
    if (cfg_q[CFG_IDENT_BIT]) begin
      mode = FDCRS_MODE_A;
    end else if (cfg_q[CFG_MFM_BIT]) begin
      mode = FDCRS_MODE_P;
    end else begin
      mode = FDCRS_MODE_M;
    end
  end

  // Codes 00 and 11 are the two fast rates
  assign high_rate = !(rate_q[1] ^ rate_q[0]);

  always_comb begin
    cfg_d = cfg_q;
    rate_d = rate_q;
    precomp_off_d = precomp_off_q;
    dma_gate_d = dma_gate_q;
    if (wr_take) begin
      case (i_address)
        IDX_MODE_CFG: begin
          cfg_d = i_writedata[7:0];
        end
        IDX_DRIVE_OUT: begin
          dma_gate_d = i_writedata[DOR_DMA_GATE_BIT];
        end
        IDX_RATE: begin
          rate_d = i_writedata[1:0];
          // Reserved bits are ignored; software is expected to keep them zero
          if (mode == FDCRS_MODE_M) begin
            precomp_off_d = i_writedata[RATE_PRECOMP_BIT];
          end
        end
        default: begin
          cfg_d = cfg_q;
        end
      endcase
    end
    // Density follows the rate, polarity by mode; i_soft_rst not involved
    if (mode == FDCRS_MODE_A) begin
      density_d = high_rate;
    end else begin
      density_d = !high_rate;
    end
  end

  // Only the hardware reset touches these; soft reset leaves them alone
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cfg_q <= CFG_RESET;
      rate_q <= RATE_RESET;
      precomp_off_q <= PRECOMP_RESET;
      dma_gate_q <= DMA_GATE_RESET;
      density_q <= DENSITY_RESET;
    end else begin
      cfg_q <= cfg_d;
      rate_q <= rate_d;
      precomp_off_q <= precomp_off_d;
      dma_gate_q <= dma_gate_d;
      density_q <= density_d;
    end
  end

  assign o_density_pin = density_q;
  assign o_rate_select = rate_q;

  // ****************************************
  // Status byte builder
  // ****************************************
  logic [7:0] st0, st1;

  fdcrs_status_enc #(
    .STEP_LIMIT(STEP_LIMIT)
  ) u_status_enc (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_cmd_start(i_cmd_start),
    .i_cmd_end(i_cmd_end),
    .i_term_code(i_term_code),
    .i_head(i_head),
    .i_drive(i_drive),
    .i_seek_done(i_seek_done),
    .i_recal_active(i_recal_active),
    .i_step_pulse(i_step_pulse),
    .i_track_zero(track_zero_input_sync),
    .i_relseek_underflow(i_relseek_underflow),
    .i_end_of_track(i_end_of_track),
    .i_crc_err(i_crc_err),
    .i_overrun(i_overrun),
    .i_sector_missing(i_sector_missing),
    .i_write_cmd_active(i_write_cmd_active),
    .i_write_prot(wp_sync),
    .i_id_search(i_id_search),
    .i_id_found(i_id_found),
    .i_index_pulse(idx_pulse),
    .i_no_data_mark(i_no_data_mark),
    .o_st0_q(st0),
    .o_st1_q(st1)
  );

  // ****************************************
  // Result phase sequencer
  // ****************************************
  fdcrs_res_type res_q, res_d;

  always_comb begin
    res_d = res_q;
    case (res_q)
      FDCRS_RES_IDLE: begin
        if (i_cmd_end) begin
          res_d = FDCRS_RES_ST0;
        end
      end
      FDCRS_RES_ST0: begin
        if (rd_take && i_address == IDX_DATA) begin
          res_d = FDCRS_RES_ST1;
        end
      end
      FDCRS_RES_ST1: begin
        if (rd_take && i_address == IDX_DATA) begin
          res_d = FDCRS_RES_IDLE;
        end
      end
      default: begin
        res_d = FDCRS_RES_IDLE;
      end
    endcase
    // A soft reset abandons any pending result bytes
    if (i_soft_rst) begin
      res_d = FDCRS_RES_IDLE;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      res_q <= FDCRS_RES_IDLE;
    end else begin
      res_q <= res_d;
    end
  end

  assign o_result_phase = (res_q != FDCRS_RES_IDLE);

  // ****************************************
  // Read data
  // ****************************************
  logic [7:0] input_status;
  logic [7:0] rd_byte;
  logic [31:0] rdata_q, rdata_d;

  always_comb begin
    input_status = 8'h00;
    case (mode)
      FDCRS_MODE_A: begin
        // Low bits undriven on the original bus; they read zero here
        input_status = 8'h00;
      end
      FDCRS_MODE_P: begin
        input_status[6:3] = DIR_P_ONES;
        input_status[2:1] = {rate_q[1], rate_q[0]};
        input_status[0] = !high_rate;
      end
      FDCRS_MODE_M: begin
        input_status[6:4] = 3'h0;
        input_status[3] = dma_gate_q;
        input_status[2] = precomp_off_q;
        input_status[1:0] = rate_q;
      end
      default: begin
        input_status = 8'h00;
      end
    endcase
    input_status[DIR_MEDIA_BIT] = !media_sync;
  end

  always_comb begin
    rd_byte = 8'h00;
    case (i_address)
      IDX_MODE_CFG: begin
        rd_byte = cfg_q;
      end
      IDX_STATUS: begin
        rd_byte = {5'h00, res_q == FDCRS_RES_ST1, res_q == FDCRS_RES_ST0,
                   o_result_phase};
      end
      IDX_DRIVE_OUT: begin
        rd_byte = {4'h0, dma_gate_q, 3'h0};
      end
      IDX_DATA: begin
        if (res_q == FDCRS_RES_ST0) begin
          rd_byte = st0;
        end else if (res_q == FDCRS_RES_ST1) begin
          rd_byte = st1;
        end else begin
          rd_byte = 8'h00;
        end
      end
      IDX_RATE: begin
        rd_byte = input_status;
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
    rdata_d = rdata_q;
    if (i_read && !ack_q) begin
      rdata_d = {24'h000000, rd_byte};
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign o_readdata = rdata_q;

endmodule : fdcrs_top
`default_nettype wire

//--- tb/fdcrs_top_sva.sv
// Checker for the bus handshake, rate, density and result phase of the bank
`timescale 1ns/1ps
`default_nettype none
module fdcrs_top_chk
  import fdcrs_pkg::*;
#(
  parameter int STEP_LIMIT = RECAL_STEP_LIMIT
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [9:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [3:0] i_byteenable,
  input wire logic [31:0] i_writedata,
  input wire logic o_waitrequest,
  input wire logic o_density_pin,
  input wire logic i_soft_rst,
  input wire logic i_cmd_end,
  input wire logic [1:0] o_rate_select,
  input wire logic o_result_phase
);
  // *****
  // Properties
  // *****
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  logic rate_wr;
  assign rate_wr = i_write && !o_waitrequest && i_address == IDX_RATE && i_byteenable[0];
  property p_wait_first;
    $rose(i_read) || $rose(i_write) |-> o_waitrequest;
  endproperty
  property p_wait_one;
    (i_read || i_write) && o_waitrequest |=> !o_waitrequest;
  endproperty
  property p_rate_wr;
    rate_wr |=> o_rate_select == $past(i_writedata[1:0]);
  endproperty
  property p_rate_keep;
    $changed(o_rate_select) |-> $past(rate_wr);
  endproperty
  property p_dens_rst;
    $rose(i_nrst) |-> o_density_pin;
  endproperty
  // Density follows a rate change one cycle late, so skip two write cycles
  property p_dens_soft;
    i_soft_rst && !i_write && !$past(i_write) |=> $stable(o_density_pin);
  endproperty
  property p_res_set;
    i_cmd_end && !i_soft_rst |=> o_result_phase;
  endproperty
  property p_res_cause;
    $rose(o_result_phase) |-> $past(i_cmd_end);
  endproperty
  a_wait_first: assert property (p_wait_first)
    else $error("no wait on first cycle");
  a_wait_one: assert property (p_wait_one)
    else $error("wait longer than one cycle");
  a_rate_wr: assert property (p_rate_wr)
    else $error("rate not loaded");
  a_rate_keep: assert property (p_rate_keep)
    else $error("rate changed without write");
  a_dens_rst: assert property (p_dens_rst)
    else $error("density low after reset");
  a_dens_soft: assert property (p_dens_soft)
    else $error("density moved on soft reset");
  a_res_set: assert property (p_res_set)
    else $error("no result phase");
  a_res_cause: assert property (p_res_cause)
    else $error("result phase without end");
  c_rate: cover property (rate_wr);
  c_res: cover property (i_cmd_end ##1 o_result_phase);
  c_soft: cover property (i_soft_rst ##1 i_soft_rst);
endmodule : fdcrs_top_chk
bind fdcrs_top fdcrs_top_chk #(.STEP_LIMIT(STEP_LIMIT)) fdcrs_top_chk_i (.i_clk, .i_nrst,
  .i_address, .i_read, .i_write, .i_byteenable, .i_writedata, .o_waitrequest, .o_density_pin,
  .i_soft_rst, .i_cmd_end, .o_rate_select, .o_result_phase);
`default_nettype wire

//--- tb/fdcrs_drive_model.sv
// Drive cable model: media changed, write protect, track zero and index pins
`timescale 1ns/1ps
`default_nettype none
module fdcrs_drive_model #(
  parameter int IDX_PERIOD = 16
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_changed,
  input wire logic i_protect,
  input wire logic i_at_zero,
  output logic o_media_n,
  output logic o_track_zero,
  output logic o_write_prot,
  output logic o_index
);
  int cnt_q;
  // Index runs free; one ID search spans more than two periods
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_q <= 0;
    end else begin
      cnt_q <= (cnt_q == IDX_PERIOD - 1) ? 0 : cnt_q + 1;
    end
  end
  assign o_index = (cnt_q < 2);
  assign o_media_n = !i_changed;
  assign o_track_zero = i_at_zero;
  assign o_write_prot = i_protect;
endmodule : fdcrs_drive_model
`default_nettype wire

//--- tb/test_fdcrs_top.sv
// Self-checking bench for the rate control and result status bank
`timescale 1ns/1ps
`default_nettype none
module test_fdcrs_top
  import fdcrs_pkg::*;
;
  localparam int SL = 4;
  logic i_clk, i_nrst, i_read, i_write, i_head, o_waitrequest, o_density_pin, o_result_phase;
  logic i_media_changed_flag_n, i_track_zero_input, i_write_prot, i_index_input;
  logic [9:0] i_address;
  logic [3:0] i_byteenable, lv;
  logic [31:0] i_writedata, o_readdata, rq;
  logic [1:0] i_term_code, i_drive, o_rate_select, r;
  logic [10:0] pl;
  logic chg, wp, tz;
  int err_total, cmp_count, i;
  fdcrs_top #(.STEP_LIMIT(SL)) fdcrs_top_i (.i_clk, .i_nrst, .i_address, .i_read, .i_write,
    .i_byteenable, .i_writedata, .o_readdata, .o_waitrequest, .i_media_changed_flag_n,
    .i_track_zero_input, .i_write_prot, .i_index_input, .o_density_pin, .i_soft_rst(lv[0]),
    .i_cmd_start(pl[0]), .i_cmd_end(pl[1]), .i_term_code, .i_head, .i_drive,
    .i_seek_done(pl[2]), .i_recal_active(lv[1]), .i_step_pulse(pl[3]),
    .i_relseek_underflow(pl[4]), .i_end_of_track(pl[5]), .i_crc_err(pl[6]),
    .i_overrun(pl[7]), .i_sector_missing(pl[8]), .i_write_cmd_active(lv[2]),
    .i_id_search(lv[3]), .i_id_found(pl[9]), .i_no_data_mark(pl[10]), .o_rate_select,
    .o_result_phase);
  fdcrs_drive_model fdcrs_drive_model_i (.i_clk, .i_nrst, .i_changed(chg), .i_protect(wp),
    .i_at_zero(tz), .o_media_n(i_media_changed_flag_n), .o_track_zero(i_track_zero_input),
    .o_write_prot(i_write_prot), .o_index(i_index_input));
  initial begin
    i_clk = 0;
    forever #4 i_clk = ~i_clk;
  end
  // *****
  // Tasks
  // *****
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  // Holds the request until waitrequest is seen low; the watchdog ends a hang
  task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] d, input logic be);
    i_address <= a;
    i_read <= !w;
    i_write <= w;
    i_writedata <= {24'h000000, d};
    i_byteenable <= {3'h0, be};
    do @(posedge i_clk); while (o_waitrequest !== 1'b0);
    rq = o_readdata;
    i_read <= 1'b0;
    i_write <= 1'b0;
    @(posedge i_clk);
  endtask : acc
  task automatic rd(input logic [9:0] a, input logic [7:0] exp, input string nm);
    acc(1'b0, a, 8'h00, 1'b1);
    chk(nm, {24'h000000, exp}, rq);
  endtask : rd
  task automatic pulse(input logic [10:0] m);
    pl <= m;
    @(posedge i_clk);
    pl <= '0;
    @(posedge i_clk);
  endtask : pulse
  task automatic fin(input logic [1:0] t, input logic h, input logic [1:0] d,
      input logic [7:0] s0, input logic [7:0] s1);
    i_term_code <= t;
    i_head <= h;
    i_drive <= d;
    pulse(11'h002);
    chk("result_phase", 32'h1, {31'h0, o_result_phase});
    rd(IDX_DATA, s0, "status0");
    rd(IDX_DATA, s1, "status1");
    chk("result_done", 32'h0, {31'h0, o_result_phase});
  endtask : fin
  function automatic logic hi(input logic [1:0] v);
    return v == 2'h0 || v == 2'h3;
  endfunction : hi
  // *****
  // Sequence
  // *****
  initial begin
    i_nrst = 0;
    i_read = 0;
    i_write = 0;
    i_address = '0;
    i_byteenable = '0;
    i_writedata = '0;
    i_term_code = '0;
    i_head = 0;
    i_drive = '0;
    pl = '0;
    lv = '0;
    chg = 0;
    wp = 0;
    tz = 0;
    err_total = 0;
    cmp_count = 0;
    repeat (3) @(posedge i_clk);
    chk("density_rst", 32'h1, {31'h0, o_density_pin});
    i_nrst <= 1'b1;
    @(posedge i_clk);
    rd(IDX_MODE_CFG, CFG_RESET, "mode_cfg");
    for (i = 0; i < 4; i++) begin
      r = i[1:0];
      acc(1'b1, IDX_RATE, {6'h00, r}, 1'b1);
      chk("rate_a", {30'h0, r}, {30'h0, o_rate_select});
      rd(IDX_RATE, 8'h00, "in_a");
      chk("dens_a", {31'h0, hi(r)}, {31'h0, o_density_pin});
    end
    chg <= 1'b1;
    acc(1'b1, IDX_MODE_CFG, 8'h20, 1'b1);
    for (i = 0; i < 4; i++) begin
      r = i[1:0];
      acc(1'b1, IDX_RATE, {6'h00, r}, 1'b1);
      rd(IDX_RATE, {5'h1F, r, !hi(r)}, "in_p");
      chk("dens_p", {31'h0, !hi(r)}, {31'h0, o_density_pin});
    end
    acc(1'b1, IDX_MODE_CFG, 8'h00, 1'b1);
    for (i = 0; i < 4; i++) begin
      r = i[1:0];
      acc(1'b1, IDX_DRIVE_OUT, {4'h0, r[1], 3'h0}, 1'b1);
      acc(1'b1, IDX_RATE, {5'h00, r[0], r}, 1'b1);
      rd(IDX_RATE, {4'h8, r[1], r[0], r}, "in_m");
    end
    lv[0] <= 1'b1;
    repeat (2) @(posedge i_clk);
    lv[0] <= 1'b0;
    @(posedge i_clk);
    rd(IDX_RATE, 8'h8F, "in_soft");
    chk("dens_soft", 32'h0, {31'h0, o_density_pin});
    acc(1'b1, 10'h100, 8'h01, 1'b1);
    rd(10'h100, 8'h00, "unmapped");
    acc(1'b1, IDX_RATE, 8'h01, 1'b0);
    chk("rate_no_lane", 32'h3, {30'h0, o_rate_select});
    rd(IDX_DATA, 8'h00, "data_idle");
    i_nrst <= 1'b0;
    repeat (3) @(posedge i_clk);
    chk("rate_hard", 32'h2, {30'h0, o_rate_select});
    chk("dens_hard", 32'h1, {31'h0, o_density_pin});
    i_nrst <= 1'b1;
    @(posedge i_clk);
    acc(1'b1, IDX_MODE_CFG, 8'h00, 1'b1);
    rd(IDX_RATE, 8'h82, "in_m_reset");
    pulse(11'h001);
    pulse(11'h5F4);
    fin(2'h1, 1'b1, 2'h2, 8'h76, 8'hB5);
    wp <= 1'b1;
    pulse(11'h001);
    lv[3:1] <= 3'h7;
    for (i = 0; i < SL; i++) pulse(11'h008);
    repeat (48) @(posedge i_clk);
    lv[3:1] <= 3'h0;
    wp <= 1'b0;
    fin(2'h3, 1'b0, 2'h1, 8'hD1, 8'h03);
    for (i = 0; i < 4; i++) begin
      pulse(11'h001);
      fin(i[1:0], 1'b0, 2'h0, {i[1:0], 6'h00}, 8'h00);
    end
    // Seek end in the same cycle as command start must survive the clear
    pulse(11'h005);
    fin(2'h0, 1'b0, 2'h0, 8'h20, 8'h00);
    // Soft reset abandons pending result bytes
    pulse(11'h002);
    lv[0] <= 1'b1;
    @(posedge i_clk);
    lv[0] <= 1'b0;
    @(posedge i_clk);
    chk("res_soft", 32'h0, {31'h0, o_result_phase});
    rd(IDX_DATA, 8'h00, "data_soft");
    end_of_test();
  end
  initial begin
    repeat (5000) @(posedge i_clk);
    err_total++;
    end_of_test();
  end
endmodule : test_fdcrs_top
`default_nettype wire
